/* File: rtl/crc_engine.sv */
// checksum engine: byte-fed or flash-scanning 16-bit crc with sfr access
// assumes cpu drives sfr strobes on mclk, flash answers the cycle after
//
// What this block does
// (R1) polynomial 0x1021 for every byte
// (R2) seed is all zeros or all ones
// (R3) seed select bit picks starting value
// (R4) writing initialise bit loads selected seed
// (R5) software feeds message bytes in order
// (R6) each input byte folded in automatically unless it leaves the queue in an init or data write cycle
// (R7) automatic mode over 256-byte flash blocks
// (R8) software writes start page first
// (R9) software sets auto enable first
// (R10) software writes block count first
// (R11) any control write starts pass when enabled and block count is nonzero
// (R12) cpu stalled until all blocks done
// (R13) software clears auto enable afterward
// (R14) 16-bit result read bytewise
// (R15) byte pointer advances on each data access
// (R16) result holds until init, overwrite, input byte or flash scan
// (R17) flash fetched ascending from page start
`timescale 1ns/1ps
`default_nettype none
module crc_engine #(
    parameter int fifo_depth = 8
) (
    input  wire logic mclk,
    input  wire logic rst,
    crc_sfr_if.engine bus
);
    typedef enum logic [1:0] {idle, fetch, fold, last} scan_t;
    // ------------------------------------------------------------
    // byte fold function
    // ------------------------------------------------------------
    function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                             input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) begin
            r = r[15] ? ((r << 1) ^ crc_pkg::crc_poly) : (r << 1); // see R1
        end
        return r;
    endfunction
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [15:0] result_r;
    logic        seed_select_r;
    logic        result_byte_pointer_r;
    logic [7:0]  auto_control_r;
    logic [7:0]  block_count_r;
    logic [7:0]  bit_reverse_r;
    logic [7:0]  rdata_r;
    logic        stall_r;
    logic [15:0] faddr_r;
    logic        frd_r;
    logic [7:0]  blocks_left_r;
    scan_t       state_r;
    // strobe decode
    wire wr_ctrl  = bus.wr && bus.addr == crc_pkg::ctrl_addr;
    wire wr_in    = bus.wr && bus.addr == crc_pkg::in_addr;
    wire wr_data  = bus.wr && bus.addr == crc_pkg::data_addr;
    wire rd_data  = bus.rd && bus.addr == crc_pkg::data_addr;
    wire auto_en  = auto_control_r[crc_pkg::auto_en_bit];
    wire init_hit = wr_ctrl && bus.wdata[crc_pkg::ctrl_init_bit];
    wire new_seed = bus.wdata[crc_pkg::ctrl_seed_bit];
    wire [15:0] seed_val = new_seed ? crc_pkg::seed_ones
                                    : crc_pkg::seed_zero; // see R2 R3
    wire start_scan = wr_ctrl && auto_en && state_r == idle; // see R11
    wire [7:0] ptr_byte = result_byte_pointer_r ? result_r[15:8]
                                                : result_r[7:0]; // see R14
    // manual bytes queue ahead of the folder
    logic [7:0] q_data;
    logic       q_valid;
    wire        fold_manual = q_valid && state_r == idle;
    // the cpu is held during scans and folding drains one byte per
    // cycle, so the queue cannot fill and its ready is not needed
    byte_fifo #(.width(8), .depth(fifo_depth)) in_q (
        .mclk      (mclk),
        .rst       (rst),
        .in_data   (bus.wdata),
        .in_valid  (wr_in),
        .in_ready  (),
        .out_data  (q_data),
        .out_valid (q_valid),
        .out_ready (fold_manual)
    );
    // readback mux
    wire [7:0] rd_mux =
        bus.addr == crc_pkg::ctrl_addr ?
            {4'h0, 1'b0, seed_select_r, 1'b0, result_byte_pointer_r} :
        bus.addr == crc_pkg::data_addr    ? ptr_byte :
        bus.addr == crc_pkg::count_addr   ? block_count_r :
        bus.addr == crc_pkg::reverse_addr ? bit_reverse_r :
        bus.addr == crc_pkg::auto_addr    ? auto_control_r :
        crc_pkg::reset_byte;
    // bit-reverse register mirrors input reversed on read
    logic [7:0] rev_in;
    always_comb begin
        for (int i = 0; i < 8; i++) rev_in[i] = bus.wdata[7-i];
    end
    // ------------------------------------------------------------
    // register writes and read data
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            seed_select_r         <= 1'b0;
            result_byte_pointer_r <= 1'b0;
            auto_control_r        <= 8'h00;
            block_count_r         <= 8'h00;
            bit_reverse_r         <= 8'h00;
            rdata_r               <= 8'h00;
        end else begin
            rdata_r <= bus.rd ? rd_mux : 8'h00;
            if (wr_ctrl) begin
                seed_select_r         <= new_seed;
                result_byte_pointer_r <= bus.wdata[crc_pkg::ctrl_ptr_bit];
            end else if (wr_data || rd_data) begin
                result_byte_pointer_r <= ~result_byte_pointer_r; // see R15
            end
            if (bus.wr && bus.addr == crc_pkg::auto_addr)
                auto_control_r <= bus.wdata; // see R8 R9 R13
            if (bus.wr && bus.addr == crc_pkg::count_addr)
                block_count_r <= bus.wdata; // see R10
            if (bus.wr && bus.addr == crc_pkg::reverse_addr)
                bit_reverse_r <= rev_in;
        end
    end
    // ------------------------------------------------------------
    // result register
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            result_r <= crc_pkg::seed_zero;
        end else if (init_hit) begin
            result_r <= seed_val; // see R4
        end else if (wr_data) begin
            if (result_byte_pointer_r) result_r[15:8] <= bus.wdata;
            else result_r[7:0] <= bus.wdata;
        end else if (state_r == fold || state_r == last) begin
            result_r <= crc_byte(result_r, bus.flash_data); // see R7
        end else if (fold_manual) begin
            result_r <= crc_byte(result_r, q_data); // see R5 R6
        end
        // otherwise held, see R16
    end
    // ------------------------------------------------------------
    // automatic flash scan
    // ------------------------------------------------------------
    wire block_end = faddr_r[7:0] == 8'hff;
    wire scan_done = block_end && blocks_left_r <= 8'd1;
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_r       <= idle;
            stall_r       <= 1'b0;
            faddr_r       <= 16'h0000;
            frd_r         <= 1'b0;
            blocks_left_r <= 8'h00;
        end else begin
            case (state_r)
                idle: begin
                    if (start_scan && block_count_r != 8'h00) begin
                        state_r       <= fetch;
                        stall_r       <= 1'b1; // see R12
                        faddr_r       <= {1'b0,
                            auto_control_r[6:0] & crc_pkg::auto_page_mask,
                            8'h00}; // see R17
                        frd_r         <= 1'b1;
                        blocks_left_r <= block_count_r;
                    end
                end
                fetch: begin
                    frd_r   <= 1'b0;
                    state_r <= scan_done ? last : fold;
                end
                fold: begin
                    if (block_end) blocks_left_r <= blocks_left_r - 8'd1;
                    faddr_r <= faddr_r + 16'd1; // see R17
                    frd_r   <= 1'b1;
                    state_r <= fetch;
                end
                last: begin
                    stall_r <= 1'b0; // see R12
                    state_r <= idle;
                end
                default: state_r <= idle;
            endcase
        end
    end
    assign bus.rdata      = rdata_r;
    assign bus.stall      = stall_r;
    assign bus.flash_addr = faddr_r;
    assign bus.flash_rd   = frd_r;
endmodule
`default_nettype wire

/* File: rtl/crc_pkg.sv */
// shared constants for the checksum engine and its cpu-side partner
// assumes one clock, synchronous active-high reset
package crc_pkg;
    // register offsets in special function space
    localparam logic [7:0] ctrl_addr     = 8'h84;
    localparam logic [7:0] in_addr       = 8'h85;
    localparam logic [7:0] data_addr     = 8'h86;
    localparam logic [7:0] count_addr    = 8'h9a;
    localparam logic [7:0] reverse_addr  = 8'h9c;
    localparam logic [7:0] auto_addr     = 8'h9e;
    // control register fields
    localparam int ctrl_init_bit  = 3;
    localparam int ctrl_seed_bit  = 2;
    localparam int ctrl_ptr_bit   = 0;
    // automatic control fields
    localparam int auto_en_bit    = 7;
    localparam logic [6:0] auto_page_mask = 7'h7f;
    // generator and seeds
    localparam logic [15:0] crc_poly  = 16'h1021;
    localparam logic [15:0] seed_zero = 16'h0000;
    localparam logic [15:0] seed_ones = 16'hffff;
    localparam logic [7:0]  reset_byte = 8'h00;
    // bytes per flash block
    localparam int block_bytes = 256;
endpackage

/* File: rtl/crc_sfr_if.sv */
// special function register link between cpu side and checksum engine
// assumes both ends share mclk
`timescale 1ns/1ps
`default_nettype none
interface crc_sfr_if;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic        stall;
    logic [15:0] flash_addr;
    logic        flash_rd;
    logic [7:0]  flash_data;
    modport engine (input addr, wdata, wr, rd, flash_data,
                    output rdata, stall, flash_addr, flash_rd);
    modport cpu    (output addr, wdata, wr, rd, flash_data,
                    input rdata, stall, flash_addr, flash_rd);
endinterface
`default_nettype wire

/* File: rtl/byte_fifo.sv */
// small valid/ready fifo for bytes headed to the engine
// assumes single clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
    parameter int width = 8,
    parameter int depth = 8
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic [width-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [width-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int aw = $clog2(depth);
    logic [width-1:0] mem [depth];
    logic [aw:0]      wp_r;
    logic [aw:0]      rp_r;
    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;
    assign in_ready  = (wp_r - rp_r) != (aw+1)'(depth);
    assign out_valid = wp_r != rp_r;
    assign out_data  = mem[rp_r[aw-1:0]];
    // pointer and storage update
    always_ff @(posedge mclk) begin
        if (rst) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (push) wp_r <= wp_r + (aw+1)'(1);
            if (pop) rp_r <= rp_r + (aw+1)'(1);
        end
    end
    always_ff @(posedge mclk) begin
        if (push) mem[wp_r[aw-1:0]] <= in_data;
    end
endmodule
`default_nettype wire

/* File: rtl/crc_cpu_end.sv */
// cpu-side partner: turns user commands into sfr strobes, models flash
// assumes the user holds commands while busy is high
`timescale 1ns/1ps
`default_nettype none
module crc_cpu_end #(
    parameter int flash_words = 65536
) (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic [7:0] cmd_addr,
    input  wire logic [7:0] cmd_wdata,
    input  wire logic       cmd_wr,
    input  wire logic       cmd_rd,
    output logic      [7:0] cmd_rdata,
    output logic            cmd_rvalid,
    output logic            busy,
    crc_sfr_if.cpu          bus
);
    logic [7:0] flash_mem [flash_words];
    logic [7:0] addr_r;
    logic [7:0] wdata_r;
    logic       wr_r;
    logic       rd_r;
    logic       rvalid_r;
    logic       busy_r;
    logic [7:0] fdata_r;
    // issue strobes only when the engine is not stalling, see R12
    wire go = !bus.stall && !busy_r;
    always_ff @(posedge mclk) begin
        if (rst) begin
            addr_r   <= 8'h00;
            wdata_r  <= 8'h00;
            wr_r     <= 1'b0;
            rd_r     <= 1'b0;
            rvalid_r <= 1'b0;
            busy_r   <= 1'b0;
        end else begin
            wr_r     <= go && cmd_wr; // see R5 R8 R9 R10 R11 R13
            rd_r     <= go && cmd_rd && !cmd_wr;
            rvalid_r <= rd_r;
            busy_r   <= bus.stall;
            if (go && (cmd_wr || cmd_rd)) begin
                addr_r  <= cmd_addr;
                wdata_r <= cmd_wdata;
            end
        end
    end
    // flash read answers one cycle after request
    always_ff @(posedge mclk) begin
        if (bus.flash_rd) fdata_r <= flash_mem[bus.flash_addr];
    end
    assign bus.addr       = addr_r;
    assign bus.wdata      = wdata_r;
    assign bus.wr         = wr_r;
    assign bus.rd         = rd_r;
    assign bus.flash_data = fdata_r;
    // engine read data stand only in the cycle after the strobe,
    // which is the cycle cmd_rvalid is high
    assign cmd_rdata      = bus.rdata;
    assign cmd_rvalid     = rvalid_r;
    assign busy           = busy_r;
endmodule
`default_nettype wire

/* File: test/crc_sfr_chk.sv */
// assertions on the sfr link between cpu side and checksum engine
// assumes the bench instantiates it beside the interface, one clock
`timescale 1ns/1ps
`default_nettype none
module crc_sfr_chk (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic [7:0]  addr,
    input wire logic [7:0]  wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [7:0]  rdata,
    input wire logic        stall,
    input wire logic [15:0] flash_addr,
    input wire logic        flash_rd,
    input wire logic [7:0]  flash_data
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // helper state: auto settings and fetch count
    // ------------------------------------------------------------
    logic [6:0]  page_r;
    logic        en_r;
    logic [7:0]  cnt_r;
    logic [7:0]  run_r;
    logic [16:0] got_r;
    wire logic   ctrl_wr = wr && addr == crc_pkg::ctrl_addr;
    wire logic   go = ctrl_wr && en_r && cnt_r != 8'h00;
    always_ff @(posedge mclk) begin
        if (rst) begin
            en_r  <= 1'b0;
            cnt_r <= 8'h00;
            got_r <= 17'h0;
        end else begin
            if (wr && addr == crc_pkg::auto_addr) begin
                en_r   <= wdata[crc_pkg::auto_en_bit];
                page_r <= wdata[6:0];
            end
            if (wr && addr == crc_pkg::count_addr)
                cnt_r <= wdata;
            if (go)
                run_r <= cnt_r;
            got_r <= go ? 17'h0 : got_r + {16'h0, flash_rd};
        end
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_rdata_idle:
    assert property (!$past(rd) |-> rdata == 8'h00) else $error("rdata not idle");
    a_scan_start:
    assert property (go |=> stall) else $error("scan did not start");
    a_no_start:
    assert property (ctrl_wr && !go && !stall |=> !stall)
        else $error("scan started without enable or count");
    a_fetch_in_stall:
    assert property (flash_rd |-> stall) else $error("fetch outside scan");
    a_cpu_held:
    assert property (stall |-> !wr && !rd) else $error("cpu ran during scan");
    a_fetch_step:
    assert property (flash_rd ##2 flash_rd |->
        flash_addr == $past(flash_addr, 2) + 16'h0001)
        else $error("fetch address not ascending");
    a_first_fetch:
    assert property (go |-> ##[1:8] (flash_rd &&
        flash_addr == {1'b0, page_r, 8'h00})) else $error("bad first fetch");
    a_fetch_total:
    assert property ($fell(stall) |-> got_r == {1'b0, run_r, 8'h00})
        else $error("wrong number of fetched bytes");
    c_scan: cover property (go);
    c_read: cover property (rd && addr == crc_pkg::data_addr);
    c_feed: cover property (wr && addr == crc_pkg::in_addr);
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// self-checking bench: cpu end and engine joined by the sfr interface
// assumes flash model array flash_mem inside the cpu end
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  cmd_addr = 8'h00;
    logic [7:0]  cmd_wdata = 8'h00;
    logic        cmd_wr = 1'b0;
    logic        cmd_rd = 1'b0;
    logic [7:0]  cmd_rdata;
    logic        cmd_rvalid;
    logic        busy;
    logic [15:0] exp;
    int          fail_count = 0;
    int          n_compared = 0;
    crc_sfr_if bus ();
    always #25 mclk = ~mclk;
    crc_engine u_crc_engine (.mclk(mclk), .rst(rst), .bus(bus.engine));
    crc_cpu_end u_crc_cpu_end (.mclk(mclk), .rst(rst), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
        .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid), .busy(busy),
        .bus(bus.cpu));
    crc_sfr_chk u_crc_sfr_chk (.mclk(mclk), .rst(rst), .addr(bus.addr),
        .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata),
        .stall(bus.stall), .flash_addr(bus.flash_addr),
        .flash_rd(bus.flash_rd), .flash_data(bus.flash_data));
    // ------------------------------------------------------------
    // access tasks and reference model
    // ------------------------------------------------------------
    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic [7:0]  d);
        for (int i = 7; i >= 0; i--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? crc_pkg::crc_poly : 16'h0);
        return c;
    endfunction
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        #1;
        while (busy !== 1'b0 && n < 3000) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (busy !== 1'b0) begin
            fail_count++;
            $display("ERROR busy expected 0 seen %b", busy);
        end
        @(posedge mclk);
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        wait_idle();
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_wr <= 1'b1;
        @(posedge mclk);
        cmd_wr <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a,
                          input logic [7:0] e);
        int n;
        n = 0;
        wait_idle();
        cmd_addr <= a;
        cmd_rd <= 1'b1;
        @(posedge mclk);
        cmd_rd <= 1'b0;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (cmd_rvalid !== 1'b1 && n < 8);
        n_compared++;
        if (cmd_rvalid !== 1'b1 || cmd_rdata !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, e, cmd_rdata);
        end
    endtask
    task automatic res_chk(input logic [15:0] e);
        rd_chk("result_low", crc_pkg::data_addr, e[7:0]);
        rd_chk("result_high", crc_pkg::data_addr, e[15:8]);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        for (int s = 0; s < 2; s++) begin
            reg_wr(crc_pkg::ctrl_addr, s ? 8'h0c : 8'h08);
            exp = s ? crc_pkg::seed_ones : crc_pkg::seed_zero;
            res_chk(exp);
            rd_chk("wrap", crc_pkg::data_addr, exp[7:0]);
        end
        // manual feed of ten bytes
        reg_wr(crc_pkg::ctrl_addr, 8'h0c);
        exp = 16'hffff;
        for (int i = 0; i < 10; i++) begin
            reg_wr(crc_pkg::in_addr, 8'(8'h31 + i));
            exp = crc_step(exp, 8'(8'h31 + i));
        end
        reg_wr(crc_pkg::ctrl_addr, 8'h00);
        res_chk(exp);
        res_chk(exp);
        // overwrite through data register, then fold one byte
        reg_wr(crc_pkg::data_addr, 8'h34);
        reg_wr(crc_pkg::data_addr, 8'h12);
        reg_wr(crc_pkg::in_addr, 8'ha5);
        res_chk(crc_step(16'h1234, 8'ha5));
        reg_wr(crc_pkg::reverse_addr, 8'h01);
        rd_chk("bit_reverse", crc_pkg::reverse_addr, 8'h80);
        rd_chk("unmapped", 8'h90, 8'h00);
        // zero count: control write must not scan
        reg_wr(crc_pkg::auto_addr, 8'h83);
        reg_wr(crc_pkg::count_addr, 8'h00);
        reg_wr(crc_pkg::ctrl_addr, 8'h00);
        rd_chk("block_count", crc_pkg::count_addr, 8'h00);
        rd_chk("auto_control", crc_pkg::auto_addr, 8'h83);
        // scan of two blocks from page 3
        reg_wr(crc_pkg::auto_addr, 8'h03);
        reg_wr(crc_pkg::ctrl_addr, 8'h0c);
        exp = 16'hffff;
        for (int a = 0; a < 512; a++) begin
            u_crc_cpu_end.flash_mem[16'h0300 + a] = 8'(a * 7 + 1);
            exp = crc_step(exp, 8'(a * 7 + 1));
        end
        reg_wr(crc_pkg::auto_addr, 8'h83);
        reg_wr(crc_pkg::count_addr, 8'h02);
        reg_wr(crc_pkg::ctrl_addr, 8'h04);
        repeat (4) @(posedge mclk);
        reg_wr(crc_pkg::auto_addr, 8'h03);
        res_chk(exp);
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        end_of_test();
    end
endmodule
`default_nettype wire
